// file: dtcr_cpu_if.sv
// cpu-domain control and status carried between the register and its sync stage
interface dtcr_cpu_if;
    logic peripheral_reset_request_req;
    logic processor_reset_request_req;
    logic probe_memory_enable;
    logic vecsel;
    logic brk_req;
    logic peripheral_reset_request_ack;
    logic processor_reset_request_ack;
    logic probe_memory_enable_eff;
    logic vecsel_eff;
    logic dmode;
    logic lowpwr;
    logic halt;
    logic tcdis;
    modport reg_side (output peripheral_reset_request_req, processor_reset_request_req, probe_memory_enable, vecsel, brk_req,
                      input peripheral_reset_request_ack, processor_reset_request_ack, probe_memory_enable_eff, vecsel_eff,
                      dmode, lowpwr, halt, tcdis);
    modport sync_side (input peripheral_reset_request_req, processor_reset_request_req, probe_memory_enable, vecsel, brk_req,
                       output peripheral_reset_request_ack, processor_reset_request_ack, probe_memory_enable_eff, vecsel_eff,
                       dmode, lowpwr, halt, tcdis);
endinterface

// file: dtcr_map.svh
// width, field positions, debug vector addresses and timing counts of the debug control register
`ifndef DTCR_MAP_SVH
`define DTCR_MAP_SVH
`define DTCR_WIDTH        32
`define DTCR_BIT_ROCC     31
`define DTCR_BIT_SIZE_HI  30
`define DTCR_BIT_SIZE_LO  29
`define DTCR_BIT_TCDIS    23
`define DTCR_BIT_LOWPWR   22
`define DTCR_BIT_HALT     21
`define DTCR_BIT_PERIPHERAL_RESET_REQUEST   20
`define DTCR_BIT_DIR      19
`define DTCR_BIT_PEND     18
`define DTCR_BIT_PROCESSOR_RESET_REQUEST    16
`define DTCR_BIT_PROBE_MEMORY_ENABLE   15
`define DTCR_BIT_VECSEL   14
`define DTCR_BIT_BREAK    12
`define DTCR_BIT_DMODE    3
`define DTCR_VEC_NORMAL   32'hBFC00480
`define DTCR_VEC_PROBE    32'hFF200200
`define DTCR_SYNC_STAGES  2
`endif

// file: dtcr_pkg.sv
// types shared by the debug control register modules
package dtcr_pkg;
    typedef enum logic [2:0] {
        DTCR_IDLE_TYPE_S   = 3'h1,
        DTCR_ARMED_S       = 3'h2,
        DTCR_TAKEN_S       = 3'h4
    } dtcr_brk_state_type;
    typedef logic [1:0] dtcr_size_type;
endpackage

// file: dtcr_probe.sv
// partner model: debug probe driving the test access port strobes
module dtcr_probe (
    // pacing clock
    input  wire logic clk_i,
    // serial data from the register
    input  wire logic tdo_i,
    // tap strobes towards the register
    output logic      tck_o,
    output logic      tdi_o,
    output logic      sel_o,
    output logic      capture_o,
    output logic      shift_o,
    output logic      update_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tck_o = 1'b0;
        tdi_o = 1'b0;
        sel_o = 1'b0;
        capture_o = 1'b0;
        shift_o = 1'b0;
        update_o = 1'b0;
    end

    // half of a 160 ns test clock period
    task automatic half();
        repeat (8) @(negedge clk_i);
    endtask

    // test clock only toggles inside frames
    task automatic tick(output logic bit_o);
        half();
        bit_o = tdo_i;
        tck_o = 1'b1;
        half();
        tck_o = 1'b0;
    endtask

    // capture, 32 shifts lsb first, update
    task automatic scan(input logic [31:0] wdata, output logic [31:0] rdata);
        logic b;
        sel_o = 1'b1;
        capture_o = 1'b1;
        tick(b);
        capture_o = 1'b0;
        shift_o = 1'b1;
        for (int i = 0; i < 32; i++) begin
            tdi_o = wdata[i];
            tick(b);
            rdata[i] = b;
        end
        shift_o = 1'b0;
        update_o = 1'b1;
        tick(b);
        update_o = 1'b0;
        sel_o = 1'b0;
        tdi_o = ~tdi_o;
        half();
        half();
    endtask
endmodule

// file: dtcr_sync.sv
// two-flop synchronisers for the status inputs and tap strobes that arrive from outside
module dtcr_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    meta[g] <= 1'b0;
                    q_o[g]  <= 1'b0;
                end else begin
                    meta[g] <= d_i[g];
                    q_o[g]  <= meta[g];
                end
            end
        end
    endgenerate
endmodule

// file: dtcr_tck.sv
// test-clock front end: synchronises tck and tap strobes and finds tck rising edges
module dtcr_tck (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic tck_i,
    input  wire logic tdi_i,
    input  wire logic sel_i,
    input  wire logic capture_i,
    input  wire logic shift_i,
    input  wire logic update_i,
    output logic      tck_rise_o,
    output logic      tdi_o,
    output logic      sel_o,
    output logic      capture_o,
    output logic      shift_o,
    output logic      update_o
);
    logic [5:0] synced;
    logic       tck_prev;
    dtcr_sync #(.WIDTH(6)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({tck_i, tdi_i, sel_i, capture_i, shift_i, update_i}),
        .q_o     (synced)
    );
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= synced[5];
        end
    end
    assign tck_rise_o = synced[5] & ~tck_prev;
    assign tdi_o      = synced[4];
    assign sel_o      = synced[3];
    assign capture_o  = synced[2];
    assign shift_o    = synced[1];
    assign update_o   = synced[0];
endmodule

// file: dtcr_top.sv
// debug control/status scan register reached through the test access port
`include "dtcr_map.svh"

// How it works
// RQ1 - 32-bit register in the scan path only while its instruction is selected
// RQ2 - update blocked while reset-occurred is 1 unless written to 0
// RQ3 - cpu reset loads reset values; test-logic reset leaves them alone
// RQ4 - cpu reset acts without test clock; applied at once, with no test-clock edge needed
// RQ5 - reset-occurred set by cpu reset, held during reset, cleared by writing 0
// RQ6 - bits 30:29 show access size code, read only
// RQ7 - bit 23 shows thread context disabled
// RQ8 - bit 22 samples low-power state at capture
// RQ9 - bit 21 samples stopped system clock at capture
// RQ10 - bit 20 drives peripheral reset; read-back shows the written register bit, not the cpu-domain output
// RQ11 - bit 19 shows direction of pending access, 1 write
// RQ12 - bit 18 shows pending access; write 0 ends it, write 1 ignored
// RQ13 - reset-occurred clears pending; finishing refused while it stays set
// RQ14 - fast transfer scan may also clear the pending flag
// RQ15 - bit 16 drives processor reset, self-clears through the reset
// RQ16 - bit 15 tells cpu probe serves memory, mirrored through one same-clock flop
// RQ17 - probe enable, vector select, break reset to boot indication
// RQ18 - bit 14 picks debug vector, normal or probe memory address
// RQ19 - probe must not set vector select while probe enable is 0
// RQ20 - enable and vector changes before a break apply to that break
// RQ21 - bit 12 raises debug exception unless in debug mode; cleared when taken
// RQ22 - bit 3 shows debug mode
// RQ23 - debug mode sampled into the scan register at capture
// RQ24 - status bits cross clock domains through two-flop synchronisers; control bits reach the outputs through one same-clock flop
module dtcr_top
    import dtcr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // test access port, from the tap controller
    input  wire logic        tck_i,
    input  wire logic        trst_b_i,
    input  wire logic        tdi_i,
    input  wire logic        sel_i,
    input  wire logic        capture_i,
    input  wire logic        shift_i,
    input  wire logic        update_i,
    input  wire logic        fast_clear_i,
    output logic             tdo_o,
    // cpu side
    input  wire logic        boot_ind_i,
    input  wire logic        acc_start_i,
    input  wire logic        acc_write_i,
    input  wire logic [1:0]  acc_size_i,
    input  wire logic        dmode_i,
    input  wire logic        lowpwr_i,
    input  wire logic        halt_i,
    input  wire logic        tcdis_i,
    input  wire logic        brk_taken_i,
    output logic             access_pending_o,
    output logic             peripheral_reset_output_o,
    output logic             processor_reset_output_o,
    output logic             probe_memory_enable_o,
    output logic             cpu_side_debug_register_o,
    output logic             debug_break_request_o,
    output logic [31:0]      debug_vector_o
);

    // ------------------------------------------------------------
    // synchronised tap strobes and cpu status
    // ------------------------------------------------------------
    logic tck_rise;
    logic tdi_s;
    logic sel_s;
    logic cap_s;
    logic shf_s;
    logic upd_s;
    logic [3:0] stat_s;
    logic upd_prev;
    logic upd_pulse;
    logic boot_seen;
    logic [`DTCR_WIDTH-1:0] shreg;

    dtcr_cpu_if cif ();

    dtcr_tck u_tck (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .tck_i      (tck_i),
        .tdi_i      (tdi_i),
        .sel_i      (sel_i),
        .capture_i  (capture_i),
        .shift_i    (shift_i),
        .update_i   (update_i),
        .tck_rise_o (tck_rise),
        .tdi_o      (tdi_s),
        .sel_o      (sel_s),
        .capture_o  (cap_s),
        .shift_o    (shf_s),
        .update_o   (upd_s)
    );

    // status from the cpu side, two flops each
    dtcr_sync #(.WIDTH(4)) u_stat (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({dmode_i, lowpwr_i, halt_i, tcdis_i}),
        .q_o     (stat_s)
    ); // see RQ24
    assign cif.dmode  = stat_s[3];
    assign cif.lowpwr = stat_s[2];
    assign cif.halt   = stat_s[1];
    assign cif.tcdis  = stat_s[0];

    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    logic          rocc;
    dtcr_size_type acc_size;
    logic          acc_dir;
    logic          pend;
    logic          peripheral_reset_request;
    logic          processor_reset_request;
    logic          probe_memory_enable;
    logic          vecsel;
    logic          brk;
    logic          cap_tcdis;
    logic          cap_lowpwr;
    logic          cap_halt;
    logic          cap_dmode;
    logic          write_ok;
    logic          finish_req;
    logic          clr_ok;
    logic [`DTCR_WIDTH-1:0] cap_word;
    dtcr_brk_state_type brk_state;
    dtcr_brk_state_type next_brk_state;

    // boot strap caught after reset release
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_seen <= 1'b0;
        end else if (!boot_seen) begin
            boot_seen <= 1'b1;
        end
    end

    // update strobe, acted on at a test-clock edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            upd_prev <= 1'b0;
        end else if (tck_rise) begin
            upd_prev <= upd_s;
        end
    end
    assign upd_pulse  = tck_rise & upd_s & ~upd_prev & sel_s;         // see RQ1
    // update refused while reset-occurred stays set
    assign write_ok   = upd_pulse & (~rocc | ~shreg[`DTCR_BIT_ROCC]); // see RQ2
    assign finish_req = write_ok & ~shreg[`DTCR_BIT_PEND];
    assign clr_ok     = ~rocc;                                        // see RQ13

    // scan register: capture and shift, only while selected
    assign cap_word = {rocc, acc_size, 5'h00, cif.tcdis, cif.lowpwr, cif.halt, peripheral_reset_request,
                       acc_dir, pend, 1'b0, processor_reset_request, probe_memory_enable, vecsel, 1'b0, brk,
                       8'h00, cif.dmode, 3'h0};
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shreg <= 32'h0000_0000;
        end else if (tck_rise && sel_s && cap_s) begin
            shreg <= cap_word; // see RQ23, see RQ8, see RQ9
        end else if (tck_rise && sel_s && shf_s) begin
            shreg <= {tdi_s, shreg[`DTCR_WIDTH-1:1]}; // see RQ1
        end
    end

    // captured copies kept for the checks below
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_tcdis  <= 1'b0;
            cap_lowpwr <= 1'b0;
            cap_halt   <= 1'b0;
            cap_dmode  <= 1'b0;
        end else if (tck_rise && sel_s && cap_s) begin
            cap_tcdis  <= cif.tcdis;  // see RQ7
            cap_lowpwr <= cif.lowpwr;
            cap_halt   <= cif.halt;
            cap_dmode  <= cif.dmode;  // see RQ22
        end
    end

    // ------------------------------------------------------------
    // reset-occurred flag
    // ------------------------------------------------------------
    // cpu reset only; trst_b_i is ignored here
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rocc <= 1'b1; // see RQ5, see RQ3, see RQ4
        end else if (write_ok && !shreg[`DTCR_BIT_ROCC]) begin
            rocc <= 1'b0; // see RQ5
        end
    end

    // ------------------------------------------------------------
    // processor access handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend     <= 1'b0; // see RQ13
            acc_dir  <= 1'b0;
            acc_size <= 2'h0;
        end else if (acc_start_i && !pend) begin
            pend     <= 1'b1; // set wins
            acc_dir  <= acc_write_i; // see RQ11
            acc_size <= acc_size_i;  // see RQ6
        end else if (clr_ok && (finish_req || fast_clear_i)) begin
            pend <= 1'b0; // see RQ12, see RQ14
        end
    end

    // ------------------------------------------------------------
    // control bits written by the probe
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            peripheral_reset_request <= 1'b0;
            processor_reset_request  <= 1'b0;
        end else if (write_ok) begin
            peripheral_reset_request <= shreg[`DTCR_BIT_PERIPHERAL_RESET_REQUEST]; // see RQ10
            processor_reset_request  <= shreg[`DTCR_BIT_PROCESSOR_RESET_REQUEST];  // see RQ15
        end
    end

    // boot value applied once the strap is caught
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            probe_memory_enable <= 1'b0;
            vecsel <= 1'b0;
        end else if (!boot_seen) begin
            probe_memory_enable <= boot_ind_i; // see RQ17
            vecsel <= boot_ind_i;
        end else if (write_ok) begin
            probe_memory_enable <= shreg[`DTCR_BIT_PROBE_MEMORY_ENABLE]; // see RQ16
            vecsel <= shreg[`DTCR_BIT_VECSEL]; // see RQ18, see RQ19
        end
    end

    // ------------------------------------------------------------
    // break request state machine
    // ------------------------------------------------------------
    always_comb begin
        next_brk_state = brk_state;
        case (brk_state)
            DTCR_IDLE_TYPE_S: begin
                if (write_ok && shreg[`DTCR_BIT_BREAK] && !cif.dmode) begin
                    next_brk_state = DTCR_ARMED_S;
                end
            end
            DTCR_ARMED_S: begin
                if (brk_taken_i || cif.dmode) begin
                    next_brk_state = DTCR_TAKEN_S;
                end
            end
            DTCR_TAKEN_S: begin
                next_brk_state = DTCR_IDLE_TYPE_S;
            end
            default: begin
                next_brk_state = DTCR_IDLE_TYPE_S;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brk_state <= DTCR_IDLE_TYPE_S;
        end else if (!boot_seen && boot_ind_i) begin
            brk_state <= DTCR_ARMED_S; // see RQ17
        end else begin
            brk_state <= next_brk_state; // see RQ21
        end
    end
    assign brk = (brk_state == DTCR_ARMED_S);

    // ------------------------------------------------------------
    // cpu-domain drive: same-clock flops feed outputs
    // ------------------------------------------------------------
    assign cif.peripheral_reset_request_req = peripheral_reset_request;
    assign cif.processor_reset_request_req  = processor_reset_request;
    assign cif.probe_memory_enable     = probe_memory_enable;
    assign cif.vecsel     = vecsel;
    assign cif.brk_req    = brk;
    assign cif.peripheral_reset_request_ack = peripheral_reset_output_o;
    assign cif.processor_reset_request_ack  = processor_reset_output_o;
    assign cif.probe_memory_enable_eff = cpu_side_debug_register_o;
    assign cif.vecsel_eff = vecsel;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            peripheral_reset_output_o <= 1'b0;
            processor_reset_output_o  <= 1'b0;
            probe_memory_enable_o     <= 1'b0;
            cpu_side_debug_register_o <= 1'b0;
            debug_break_request_o     <= 1'b0;
            access_pending_o          <= 1'b0;
            debug_vector_o            <= `DTCR_VEC_NORMAL;
            tdo_o                     <= 1'b0;
        end else begin
            peripheral_reset_output_o <= cif.peripheral_reset_request_req; // see RQ10
            processor_reset_output_o  <= cif.processor_reset_request_req;  // see RQ15
            probe_memory_enable_o     <= cif.probe_memory_enable;
            cpu_side_debug_register_o <= cif.probe_memory_enable;     // see RQ16
            // vector follows settings written before the break
            debug_break_request_o     <= cif.brk_req;    // see RQ20
            access_pending_o          <= pend;
            debug_vector_o            <= cif.vecsel ? `DTCR_VEC_PROBE : `DTCR_VEC_NORMAL;
            tdo_o                     <= sel_s ? shreg[0] : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_upd_blocked;
        write_ok == 1'b0 && upd_pulse && rocc;
    endsequence

    a_rocc_blocks_update: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_upd_blocked |=> $stable(peripheral_reset_request) && $stable(processor_reset_request)) // see RQ2
        else $error("update taken while reset occurred set");
    a_rocc_clear_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        write_ok && !shreg[`DTCR_BIT_ROCC] |=> !rocc) // see RQ5
        else $error("reset occurred not cleared");
    a_pend_no_finish: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rocc && pend |=> pend) // see RQ13
        else $error("access finished while reset occurred set");
    a_pend_write_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pend && !fast_clear_i && write_ok && shreg[`DTCR_BIT_PEND] |=> pend) // see RQ12
        else $error("write of one ended access");
    a_fast_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pend && !rocc && fast_clear_i |=> !pend) // see RQ14
        else $error("fast clear ignored");
    a_peripheral_reset_request_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        write_ok ##1 1'b1 |=> peripheral_reset_output_o == $past(peripheral_reset_request)) // see RQ10
        else $error("peripheral reset output lags");
    a_vector_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        debug_vector_o == ($past(vecsel) ? `DTCR_VEC_PROBE : `DTCR_VEC_NORMAL)) // see RQ18
        else $error("debug vector wrong");
    a_brk_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        brk && brk_taken_i |=> !brk ##1 !debug_break_request_o) // see RQ21
        else $error("break request not cleared");
    a_dmode_capture: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tck_rise && sel_s && cap_s |=> shreg[`DTCR_BIT_DMODE] == cap_dmode) // see RQ23
        else $error("debug mode not captured");
    a_status_capture: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RQ8
        tck_rise && sel_s && cap_s |=>
        shreg[`DTCR_BIT_TCDIS:`DTCR_BIT_HALT] == {cap_tcdis, cap_lowpwr, cap_halt})
        else $error("cpu status not captured");
endmodule

// file: dtcr_top_tb.sv
// self-checking bench for the debug control register
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module dtcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [3:0] st; logic [31:0] wd; logic [31:0] ev;} dtcr_row_type;

    logic        clk_i = 1'b0;
    logic        rst_b_i, trst_b_i, fast_clear_i, boot_ind_i, brk_taken_i;
    logic        acc_start_i, acc_write_i, dmode_i, lowpwr_i, halt_i, tcdis_i;
    logic [1:0]  acc_size_i;
    logic        tck_i, tdi_i, sel_i, capture_i, shift_i, update_i, tdo_o;
    logic        access_pending_o, peripheral_reset_output_o, processor_reset_output_o;
    logic        probe_memory_enable_o, cpu_side_debug_register_o, debug_break_request_o;
    logic [31:0] debug_vector_o, rd, prev;
    int          fail_count = 0;
    int          compares = 0;
    dtcr_row_type rows [4] = '{
        '{4'h0, 32'h00100000, 32'hBFC00480},
        '{4'hF, 32'h00008000, 32'hBFC00480},
        '{4'h5, 32'h0000C000, 32'hFF200200},
        '{4'hA, 32'h00000000, 32'hBFC00480}};

    always #5 clk_i = ~clk_i;

    dtcr_top dut (.clk_i, .rst_b_i, .tck_i, .trst_b_i, .tdi_i, .sel_i, .capture_i,
        .shift_i, .update_i, .fast_clear_i, .tdo_o, .boot_ind_i, .acc_start_i,
        .acc_write_i, .acc_size_i, .dmode_i, .lowpwr_i, .halt_i, .tcdis_i, .brk_taken_i,
        .access_pending_o, .peripheral_reset_output_o, .processor_reset_output_o,
        .probe_memory_enable_o, .cpu_side_debug_register_o, .debug_break_request_o,
        .debug_vector_o);

    dtcr_probe probe (.clk_i, .tdo_i(tdo_o), .tck_o(tck_i), .tdi_o(tdi_i), .sel_o(sel_i),
        .capture_o(capture_i), .shift_o(shift_i), .update_o(update_i));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic reset_dut(input logic boot);
        boot_ind_i = boot;
        rst_b_i = 1'b0;
        repeat (16) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask

    task automatic pulse_in(ref logic sig);
        sig = 1'b1;
        @(negedge clk_i);
        sig = 1'b0;
        repeat (6) @(negedge clk_i);
    endtask

    task automatic start_acc(input logic w, input logic [1:0] sz);
        acc_write_i = w;
        acc_size_i = sz;
        pulse_in(acc_start_i);
    endtask

    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end

    initial begin
        {trst_b_i, fast_clear_i, brk_taken_i, acc_start_i, acc_write_i} = 5'h10;
        {dmode_i, lowpwr_i, halt_i, tcdis_i, acc_size_i} = 6'h00;
        reset_dut(1'b0);
        `CHK("vector", 32'hBFC00480, debug_vector_o)
        // write refused while reset-occurred is set
        probe.scan(32'h80100000, rd);
        `CHK("rocc", 1'b1, rd[31])
        `CHK("peripheral_reset_request", 1'b0, peripheral_reset_output_o)
        probe.scan(32'h00000000, rd);
        prev = 32'h0;
        // vector select only ever set with probe enable
        foreach (rows[i]) begin
            {tcdis_i, lowpwr_i, halt_i, dmode_i} = rows[i].st;
            probe.scan(rows[i].wd, rd);
            `CHK("status", rows[i].st, {rd[23], rd[22], rd[21], rd[3]})
            `CHK("readback", prev & 32'h8010C000, rd & 32'h8010C000)
            `CHK("peripheral_reset_request", rows[i].wd[20], peripheral_reset_output_o)
            `CHK("probe_memory_enable", rows[i].wd[15], probe_memory_enable_o)
            `CHK("mirror", rows[i].wd[15], cpu_side_debug_register_o)
            `CHK("vector", rows[i].ev, debug_vector_o)
            prev = rows[i].wd;
        end
        {tcdis_i, lowpwr_i, halt_i, dmode_i} = 4'h0;
        probe.scan(32'h00008000, rd);
        pulse_in(trst_b_i);
        trst_b_i = 1'b1;
        `CHK("trst", 1'b1, probe_memory_enable_o)
        // every size code, write of 1 to pending ignored, then write 0 ends it
        for (int s = 0; s < 4; s++) begin
            start_acc(s[0], 2'(s));
            probe.scan(32'h00048000, rd);
            `CHK("size", 2'(s), rd[30:29])
            `CHK("dir", s[0], rd[19])
            `CHK("pend", 1'b1, rd[18] & access_pending_o)
            probe.scan(32'h00008000, rd);
            `CHK("pendclr", 1'b0, access_pending_o)
        end
        start_acc(1'b0, 2'h2);
        pulse_in(fast_clear_i);
        `CHK("fastclr", 1'b0, access_pending_o)
        dmode_i = 1'b1;
        probe.scan(32'h00009000, rd);
        `CHK("brk_dm", 1'b0, debug_break_request_o)
        dmode_i = 1'b0;
        probe.scan(32'h0000D000, rd);
        `CHK("brk", 1'b1, debug_break_request_o)
        `CHK("brkvec", 32'hFF200200, debug_vector_o)
        pulse_in(brk_taken_i);
        `CHK("brkclr", 1'b0, debug_break_request_o)
        // processor reset request, then the reset it causes
        start_acc(1'b1, 2'h3);
        probe.scan(32'h00058000, rd);
        `CHK("processor_reset_request", 1'b1, processor_reset_output_o)
        reset_dut(1'b0);
        `CHK("processor_reset_request", 1'b0, processor_reset_output_o)
        `CHK("pendrst", 1'b0, access_pending_o)
        start_acc(1'b0, 2'h0);
        probe.scan(32'h80000000, rd);
        `CHK("pendkeep", 1'b1, access_pending_o)
        // clearing reset-occurred and finishing in one update: finish refused
        probe.scan(32'h00000000, rd);
        `CHK("pendref", 1'b1, access_pending_o)
        reset_dut(1'b1);
        `CHK("bootpe", 1'b1, probe_memory_enable_o)
        `CHK("bootvec", 32'hFF200200, debug_vector_o)
        `CHK("bootbrk", 1'b1, debug_break_request_o)
        pulse_in(brk_taken_i);
        `CHK("bootclr", 1'b0, debug_break_request_o)
        wrap_up();
    end
endmodule
